// *** rtl/ebc_pkg.sv ***
// Package for the external bus cycle controller: states, offsets, widths.
// Assumes a single 125 MHz clock and an asynchronous active-low reset.
// Function
// (RULE1) I/O cycles strobe io request, not memory
// (RULE2) I/O address untranslated, upper lines held low
// (RULE3) External I/O cycles get one automatic wait
// (RULE4) Reset low six clocks restarts at zero
// (RULE5) Alternate master requests bus by driving low
// (RULE6) After release, drive bus hold grant low
// (RULE7) Release bus only at machine cycle end
// (RULE8) Bus cycles three clocks plus waits; others one
// (RULE9) Wait on external wait OR internal generator
// (RULE10) Waits apply to CPU and DMA cycles
// (RULE11) External waits sit between second and third
// (RULE12) Wait sampled in second state and waits
// (RULE13) Wait low in wait state adds another
// (RULE14) Internal registers relative to 64-byte base
// (RULE15) Internal registers need upper eight bits zero
// (RULE16) Grant held until request returns high
package ebc_pkg;
	// Bus cycle states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_T1     = 6'h02,
		ST_SECOND = 6'h04,
		ST_WAIT   = 6'h08,
		ST_THIRD  = 6'h10,
		ST_HOLD   = 6'h20
	} ebc_state_e;

	// Cycle kinds requested by the core or DMA engine
	typedef enum logic [1:0] {
		CYC_MEM   = 2'h0,
		CYC_IO    = 2'h1,
		CYC_FETCH = 2'h2,
		CYC_INT   = 2'h3
	} ebc_kind_e;

	localparam int          ADDR_W        = 20;
	localparam int          IO_ADDR_W     = 16;
	localparam int          DATA_W        = 8;
	localparam int          WIN_BITS      = 6;
	localparam logic [5:0]  RELOC_OFFSET  = 6'h3f;
	localparam logic [1:0]  RELOC_RESET   = 2'h0;
	localparam logic [7:0]  IO_HIGH_ZERO  = 8'h00;
	localparam logic [3:0]  UPPER_ZERO    = 4'h0;
	localparam logic [19:0] RESTART_ADDR  = 20'h00000;
	localparam int          RESET_CYCLES  = 6;
	localparam int          WAIT_CNT_W    = 2;
	localparam int          IO_AUTO_WAITS = 1;
endpackage

// *** rtl/ebc_reset_filter.sv ***
// Reset pin qualifier: a restart is issued only after the pin has
// stayed low for the required number of consecutive clocks.
// Assumes the pin is synchronous to clock.
`timescale 1ns/1ps
module ebc_reset_filter
	import ebc_pkg::*;
#(
	parameter int LOW_CYCLES = RESET_CYCLES
) (
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset_n,
	// Pin and result
	input  wire logic reset_pin_n,
	output logic      restart
);
	logic [3:0] low_cnt_r;  // Consecutive low clocks, saturating
	logic       seen_r;     // Qualified low seen, waiting for release

	// Count low clocks; short glitches do not restart the core
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt_r <= 4'h0;
		end else if (reset_pin_n) begin
			low_cnt_r <= 4'h0;
		end else if (low_cnt_r != 4'(LOW_CYCLES)) begin
			low_cnt_r <= low_cnt_r + 4'h1;
		end
	end

	// Restart held while qualified low persists
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= !reset_pin_n && (low_cnt_r >= 4'(LOW_CYCLES - 1)); // [RULE4]
		end
	end

	assign restart = seen_r;

	// Restart rises exactly after six low clocks
	property p_reset_qual;
		@(posedge clock) disable iff (!reset_n)
		(!reset_pin_n) [*6] |=> restart;
	endproperty
	a_reset_qual: assert property (p_reset_qual) // [RULE4]
		else $error("restart missing after six low clocks");

	property p_reset_short;
		@(posedge clock) disable iff (!reset_n)
		reset_pin_n ##1 (!reset_pin_n) [*3] |=> !restart;
	endproperty
	a_reset_short: assert property (p_reset_short) // [RULE4]
		else $error("restart after short low pulse");
endmodule

// *** rtl/ebc_bus_ctrl.sv ***
// External bus cycle controller: strobes, wait states, bus hold
// exchange, reset restart and internal register window decode.
// Assumes all pins synchronous to clock; pins are shared by the
// alternate master while granted, so drivers have enables.
`timescale 1ns/1ps
module ebc_bus_ctrl
	import ebc_pkg::*;
#(
	parameter int WAIT_W = WAIT_CNT_W
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               reset_n,
	// Reset pin
	input  wire logic               reset_pin_n,
	// Cycle request from core or DMA engine
	input  wire logic               cyc_req,
	input  wire logic               cyc_dma,
	input  wire logic [1:0]         cyc_kind,
	input  wire logic               cyc_write,
	input  wire logic [ADDR_W-1:0]  cyc_addr,
	input  wire logic [DATA_W-1:0]  cyc_wdata,
	input  wire logic [WAIT_W-1:0]  prog_waits,
	output logic                    cyc_ack,
	output logic [DATA_W-1:0]       cyc_rdata,
	output logic                    restart,
	output logic [ADDR_W-1:0]       restart_addr,
	// Internal register window
	output logic                    int_hit,
	output logic [WIN_BITS-1:0]     int_offset,
	input  wire logic [DATA_W-1:0]  int_rdata,
	// External bus
	output logic [ADDR_W-1:0]       addr_out,
	output logic                    addr_oe,
	output logic [DATA_W-1:0]       data_out,
	output logic                    data_oe,
	input  wire logic [DATA_W-1:0]  data_in,
	output logic                    mem_request_strobe_n,
	output logic                    io_request_strobe_n,
	output logic                    rd_strobe_n,
	output logic                    wr_strobe_n,
	output logic                    ctrl_oe,
	input  wire logic               wait_n,
	// Bus exchange
	input  wire logic               bus_hold_request_n,
	output logic                    bus_hold_grant_n
);
	ebc_state_e              state_r;       // Bus cycle state
	logic [1:0]              kind_r;        // Latched cycle kind
	logic                    write_r;       // Latched direction
	logic [ADDR_W-1:0]       addr_r;        // Latched address
	logic [DATA_W-1:0]       wdata_r;       // Latched write data
	logic [WAIT_W-1:0]       gen_cnt_r;     // Internal waits left
	logic                    inner_r;       // Cycle hits internal regs
	logic [1:0]              reloc_r;       // Window base, bits 7:6
	logic                    wait_now;      // OR of both wait sources
	logic                    cyc_end;       // Last clock of machine cycle
	logic                    is_bus;        // Kind drives the bus
	logic                    rst_q;         // Qualified restart
	logic                    dma_r;         // Cycle issued by DMA engine

	// Internal window match on a 16-bit I/O address
	function automatic logic win_hit(input logic [IO_ADDR_W-1:0] a,
	                                 input logic [1:0] base);
		win_hit = (a[15:8] == IO_HIGH_ZERO)         // [RULE15]
		       && (a[7:6] == base);                 // [RULE14]
	endfunction

	ebc_reset_filter #(
		.LOW_CYCLES (RESET_CYCLES)
	) u_rst (
		.clock       (clock),
		.reset_n     (reset_n),
		.reset_pin_n (reset_pin_n),
		.restart     (rst_q)
	);
	assign restart      = rst_q;
	assign restart_addr = RESTART_ADDR;                 // [RULE4]

	assign is_bus   = (kind_r != CYC_INT);
	// Waits from pin or generator, same for CPU and DMA cycles
	assign wait_now = !wait_n || (gen_cnt_r != '0);     // [RULE9] [RULE10]
	// Internal ops last one clock; bus cycles end in third state
	assign cyc_end  = (state_r == ST_THIRD)
	               || (state_r == ST_T1 && !is_bus);     // [RULE8]

	// Main cycle sequencer
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= ST_IDLE;
		end else if (rst_q) begin
			state_r <= ST_IDLE;                           // [RULE4]
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (!bus_hold_request_n) begin
						state_r <= ST_HOLD;               // [RULE7]
					end else if (cyc_req) begin
						state_r <= ST_T1;
					end
				end
				ST_T1: begin
					state_r <= is_bus ? ST_SECOND : ST_IDLE;
				end
				ST_SECOND: begin                          // [RULE12]
					// Pin and generator checked in second state
					state_r <= wait_now ? ST_WAIT : ST_THIRD; // [RULE11]
				end
				ST_WAIT: begin
					state_r <= wait_now ? ST_WAIT : ST_THIRD; // [RULE13]
				end
				ST_THIRD: begin
					state_r <= ST_IDLE;
				end
				ST_HOLD: begin
					if (bus_hold_request_n) begin
						state_r <= ST_IDLE;               // [RULE16]
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Latch request at cycle start
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			kind_r  <= CYC_INT;
			write_r <= 1'b0;
			addr_r  <= '0;
			wdata_r <= '0;
			inner_r <= 1'b0;
			dma_r   <= 1'b0;
		end else if (state_r == ST_IDLE && cyc_req && bus_hold_request_n
		             && !rst_q) begin
			kind_r  <= cyc_kind;
			write_r <= cyc_write;
			wdata_r <= cyc_wdata;
			dma_r   <= cyc_dma;
			inner_r <= (cyc_kind == CYC_IO)
			        && win_hit(cyc_addr[15:0], reloc_r);
			if (cyc_kind == CYC_IO) begin
				// No translation, upper lines forced low
				addr_r <= {UPPER_ZERO, cyc_addr[15:0]}; // [RULE2]
			end else begin
				addr_r <= cyc_addr;
			end
		end
	end

	// Internal wait generator; external I/O gets at least one
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gen_cnt_r <= '0;
		end else if (state_r == ST_T1) begin
			if (kind_r == CYC_IO && !inner_r
			    && prog_waits < WAIT_W'(IO_AUTO_WAITS)) begin
				gen_cnt_r <= WAIT_W'(IO_AUTO_WAITS);      // [RULE3]
			end else if (inner_r) begin
				gen_cnt_r <= '0;                          // [RULE3]
			end else begin
				gen_cnt_r <= prog_waits;
			end
		end else if ((state_r == ST_SECOND || state_r == ST_WAIT)
		             && gen_cnt_r != '0) begin
			gen_cnt_r <= gen_cnt_r - WAIT_W'(1);
		end
	end

	// Relocation register write from an internal I/O cycle
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reloc_r <= RELOC_RESET;
		end else if (state_r == ST_THIRD && inner_r && write_r
		             && addr_r[WIN_BITS-1:0] == RELOC_OFFSET) begin
			reloc_r <= wdata_r[7:6];                      // [RULE14]
		end
	end

	// Read data capture in the third state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cyc_rdata <= '0;
		end else if (state_r == ST_THIRD && !write_r) begin
			if (!inner_r) begin
				cyc_rdata <= data_in;
			end else if (addr_r[WIN_BITS-1:0] == RELOC_OFFSET) begin
				cyc_rdata <= {reloc_r, 6'h00};
			end else begin
				cyc_rdata <= int_rdata;
			end
		end
	end

	// Strobes and pin drivers
	assign cyc_ack    = cyc_end;
	assign int_hit    = inner_r && state_r != ST_IDLE && state_r != ST_HOLD;
	assign int_offset = addr_r[WIN_BITS-1:0];
	wire   active     = is_bus
	                 && state_r inside {ST_T1, ST_SECOND, ST_WAIT, ST_THIRD};
	wire   strobe     = is_bus
	                 && state_r inside {ST_SECOND, ST_WAIT, ST_THIRD};
	assign io_request_strobe_n  = !(strobe && kind_r == CYC_IO);  // [RULE1]
	assign mem_request_strobe_n = !(strobe && kind_r != CYC_IO);  // [RULE1]
	assign rd_strobe_n = !(strobe && !write_r);
	assign wr_strobe_n = !(strobe && write_r);
	assign addr_out    = addr_r;
	assign addr_oe     = state_r != ST_HOLD;
	assign ctrl_oe     = state_r != ST_HOLD;
	assign data_out    = wdata_r;
	assign data_oe     = active && write_r;
	// Grant only once all drivers are off
	assign bus_hold_grant_n = !(state_r == ST_HOLD);   // [RULE6]

	// Checks
	sequence s_io_start;
		state_r == ST_T1 && kind_r == CYC_IO && !inner_r;
	endsequence
	property p_io_wait;
		@(posedge clock) disable iff (!reset_n || rst_q)
		s_io_start |=> ##1 (state_r == ST_WAIT);
	endproperty
	a_io_wait: assert property (p_io_wait) // [RULE3]
		else $error("external I/O cycle lacks wait state");

	property p_io_strobe;
		@(posedge clock) disable iff (!reset_n)
		!io_request_strobe_n |-> mem_request_strobe_n
		                       && addr_out[19:16] == UPPER_ZERO;
	endproperty
	a_io_strobe: assert property (p_io_strobe) // [RULE1]
		else $error("I/O strobe with memory strobe or high upper lines");

	property p_grant_end;
		@(posedge clock) disable iff (!reset_n)
		$fell(bus_hold_grant_n) |-> $past(state_r) == ST_IDLE;
	endproperty
	a_grant_end: assert property (p_grant_end) // [RULE7]
		else $error("bus released mid cycle");

	property p_grant_off;
		@(posedge clock) disable iff (!reset_n)
		!bus_hold_grant_n |-> !addr_oe && !data_oe && !ctrl_oe;
	endproperty
	a_grant_off: assert property (p_grant_off) // [RULE6]
		else $error("grant while still driving");

	property p_grant_hold;
		@(posedge clock) disable iff (!reset_n || rst_q)
		!bus_hold_grant_n && !bus_hold_request_n |=> !bus_hold_grant_n;
	endproperty
	a_grant_hold: assert property (p_grant_hold) // [RULE16]
		else $error("grant withdrawn while requested");

	property p_wait_ext;
		@(posedge clock) disable iff (!reset_n || rst_q)
		(state_r == ST_SECOND || state_r == ST_WAIT) && !wait_n |=>
		state_r == ST_WAIT;
	endproperty
	a_wait_ext: assert property (p_wait_ext) // [RULE13]
		else $error("wait low did not add a wait state");

	property p_wait_done;
		@(posedge clock) disable iff (!reset_n || rst_q)
		state_r == ST_WAIT && !wait_now |=> state_r == ST_THIRD ##1
		state_r == ST_IDLE;
	endproperty
	a_wait_done: assert property (p_wait_done) // [RULE11]
		else $error("third state not after last wait");

	property p_min_len;
		@(posedge clock) disable iff (!reset_n || rst_q)
		state_r == ST_T1 && is_bus |=> state_r == ST_SECOND ##[1:300]
		state_r == ST_THIRD;
	endproperty
	a_min_len: assert property (p_min_len) // [RULE8]
		else $error("bus cycle shorter than three clocks");

	// DMA cycles obey the same wait sources as core cycles
	property p_dma_wait;
		@(posedge clock) disable iff (!reset_n || rst_q)
		state_r == ST_SECOND && dma_r && wait_now |=> state_r == ST_WAIT;
	endproperty
	a_dma_wait: assert property (p_dma_wait) // [RULE10]
		else $error("DMA cycle skipped its wait state");
endmodule

// *** testbench/ebc_far_side.sv ***
// Far side model: memory and I/O device with a wait pin, plus the
// alternate bus master. Assumes active-low strobes from the controller.
`timescale 1ns/1ps
module ebc_far_side
	import ebc_pkg::*;
(
	// Clock and reset
	input  wire logic              clock,
	input  wire logic              reset_n,
	// Controller side
	input  wire logic              rd_strobe_n,
	input  wire logic              wr_strobe_n,
	input  wire logic [ADDR_W-1:0] addr_out,
	output logic [DATA_W-1:0]      data_in,
	output logic                   wait_n,
	output logic                   bus_hold_request_n,
	// Bench controls
	input  wire logic [2:0]        ext_waits,
	input  wire logic              hold_want
);
	logic [DATA_W-1:0] last_r;    // Last byte shown on the bus
	logic [2:0]        wcnt_r;    // Clocks with a strobe low
	logic              strobe_on; // Any read or write strobe low

	assign strobe_on = !rd_strobe_n || !wr_strobe_n;
	// Released bus flips every clock, so a stale byte never passes
	assign data_in = !rd_strobe_n ? (addr_out[7:0] ^ 8'h5a) : ~last_r;
	// Slow device: wait low for the first ext_waits strobe clocks
	assign wait_n = !(strobe_on && (wcnt_r < ext_waits));
	// Other master pulls the request low while it wants the bus
	assign bus_hold_request_n = !hold_want;

	// Bus history and wait counting
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			last_r <= 8'h00;
			wcnt_r <= 3'h0;
		end else begin
			last_r <= data_in;
			wcnt_r <= strobe_on ? wcnt_r + 3'h1 : 3'h0;
		end
	end
endmodule

// *** testbench/testbench.sv ***
// Testbench for the bus cycle controller, one task per scenario.
// Assumes ebc_far_side stands for memory, I/O and the other master.
`timescale 1ns/1ps
`define CHK(g, e) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("BAD %0t got %h want %h", $time, (g), (e)); \
	end \
end
module testbench
	import ebc_pkg::*;
;
	logic                clock = 1'b0, reset_n = 1'b0, reset_pin_n = 1'b1;
	logic                cyc_req = 1'b0, cyc_dma = 1'b0, cyc_write = 1'b0;
	logic [1:0]          cyc_kind = 2'h0, prog_waits = 2'h0;
	logic [ADDR_W-1:0]   cyc_addr = 20'h00000, addr_out, restart_addr;
	logic [DATA_W-1:0]   cyc_wdata = 8'h00, cyc_rdata, data_out, data_in;
	logic [DATA_W-1:0]   int_rdata = 8'h96; // Byte of other window regs
	logic                cyc_ack, restart, int_hit, addr_oe, data_oe;
	logic                ctrl_oe, wait_n, bus_hold_request_n;
	logic                mem_request_strobe_n, io_request_strobe_n;
	logic                rd_strobe_n, wr_strobe_n, bus_hold_grant_n;
	logic [WIN_BITS-1:0] int_offset, s_off;
	logic [2:0]          ext_waits = 3'h0;
	logic                hold_want = 1'b0;
	logic                s_mem, s_io, s_wr, s_up, s_hit; // Seen in cycle
	int                  len, mismatches = 0, tests_run = 0, cyc_cnt = 0;

	// Other window registers answer with one fixed byte
	ebc_bus_ctrl uut (.*);
	ebc_far_side far (.*);

	// 125 MHz clock
	always #4 clock = ~clock;

	// Hang guard, far above the hundred or so clocks needed
	always @(posedge clock) begin
		cyc_cnt++;
		if (cyc_cnt == 3000) begin
			mismatches++;
			results();
		end
	end

	task automatic results;
		$display("compares %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// One machine cycle; len counts its clocks up to the ack
	task automatic run_cyc(input logic [1:0] k, input logic [19:0] a,
		input logic w, input logic [7:0] wd, input logic d,
		input logic [1:0] pw, input logic [2:0] ew);
		@(posedge clock);
		{cyc_req, cyc_kind, cyc_addr, cyc_write} <= {1'b1, k, a, w};
		{cyc_wdata, cyc_dma, prog_waits} <= {wd, d, pw};
		ext_waits <= ew;
		len = 0;
		{s_mem, s_io, s_wr, s_up, s_hit} = 5'h00;
		while (len < 40) begin
			@(posedge clock);
			#1;
			len++;
			if (!mem_request_strobe_n) s_mem = 1'b1;
			if (!io_request_strobe_n) s_io = 1'b1;
			if (!wr_strobe_n) s_wr = 1'b1;
			if (!io_request_strobe_n && addr_out !== {4'h0, a[15:0]})
				s_up = 1'b1;
			if (int_hit === 1'b1) s_hit = 1'b1;
			if (int_hit === 1'b1) s_off = int_offset;
			if (cyc_ack === 1'b1) break;
		end
		// Drop the request so the idle clock takes nothing new
		@(posedge clock);
		cyc_req <= 1'b0;
		#1;
	endtask

	// Memory, fetch, DMA and internal cycle lengths
	task automatic t_mem;
		run_cyc(CYC_MEM, 20'h12345, 1'b0, 8'h00, 1'b0, 2'h0, 3'h0);
		`CHK(len, 3)
		`CHK({s_mem, s_io}, 2'b10)
		`CHK(cyc_rdata, 8'h45 ^ 8'h5a)
		run_cyc(CYC_FETCH, 20'hfff00, 1'b0, 8'h00, 1'b0, 2'h2, 3'h0);
		`CHK(len, 5)
		run_cyc(CYC_MEM, 20'h00010, 1'b1, 8'ha5, 1'b1, 2'h1, 3'h2);
		`CHK(len, 5)
		`CHK(s_wr, 1'b1)
		run_cyc(CYC_INT, 20'h00000, 1'b0, 8'h00, 1'b0, 2'h0, 3'h0);
		`CHK(len, 1)
		$display("t_mem done");
	endtask

	// External I/O: strobe choice, address, automatic wait
	task automatic t_io;
		run_cyc(CYC_IO, 20'h5a1c3, 1'b0, 8'h00, 1'b0, 2'h0, 3'h0);
		`CHK(len, 4)
		`CHK({s_mem, s_io, s_up, s_hit}, 4'b0100)
		`CHK(cyc_rdata, 8'hc3 ^ 8'h5a)
		run_cyc(CYC_IO, 20'h0a1c3, 1'b0, 8'h00, 1'b0, 2'h0, 3'h2);
		`CHK(len, 5)
		$display("t_io done");
	endtask

	// Relocatable internal window
	task automatic t_win;
		run_cyc(CYC_IO, 20'h0003f, 1'b0, 8'h00, 1'b0, 2'h3, 3'h0);
		`CHK(len, 3)
		`CHK({s_hit, s_off}, 7'h7f)
		`CHK(cyc_rdata, 8'h00)
		run_cyc(CYC_IO, 20'h0003f, 1'b1, 8'hff, 1'b0, 2'h0, 3'h0);
		run_cyc(CYC_IO, 20'h000ff, 1'b0, 8'h00, 1'b0, 2'h0, 3'h0);
		`CHK({s_hit, s_off}, 7'h7f)
		`CHK(cyc_rdata, 8'hc0)
		run_cyc(CYC_IO, 20'h0003f, 1'b0, 8'h00, 1'b0, 2'h0, 3'h0);
		`CHK({s_hit, s_io}, 2'b01)
		`CHK(len, 4)
		run_cyc(CYC_IO, 20'h001ff, 1'b0, 8'h00, 1'b0, 2'h0, 3'h0);
		`CHK(s_hit, 1'b0)
		run_cyc(CYC_IO, 20'h000ff, 1'b1, 8'h00, 1'b0, 2'h0, 3'h0);
		run_cyc(CYC_IO, 20'h00010, 1'b0, 8'h00, 1'b0, 2'h0, 3'h0);
		`CHK({s_hit, s_off}, 7'h50)
		`CHK(cyc_rdata, 8'h96)
		$display("t_win done");
	endtask

	// Hold asked in mid-cycle: grant only after the cycle ends
	task automatic t_hold;
		int   n;
		logic acked;
		n = 0;
		acked = 1'b0;
		@(posedge clock);
		cyc_kind <= CYC_MEM;
		cyc_req <= 1'b1;
		@(posedge clock);
		hold_want <= 1'b1;
		while (bus_hold_grant_n !== 1'b0 && n < 20) begin
			@(posedge clock);
			#1;
			n++;
			if (cyc_ack === 1'b1) acked = 1'b1;
		end
		`CHK(acked, 1'b1)
		// Request left high: nothing may be taken while held
		repeat (4) begin
			@(posedge clock);
			#1;
			`CHK({bus_hold_grant_n, ctrl_oe, addr_oe, cyc_ack}, 4'h0)
		end
		@(posedge clock);
		cyc_req <= 1'b0;
		hold_want <= 1'b0;
		repeat (2) @(posedge clock);
		#1;
		`CHK({bus_hold_grant_n, ctrl_oe}, 2'b11)
		$display("t_hold done");
	endtask

	// Reset pin: five low clocks ignored, longer restarts at zero
	task automatic t_rst;
		@(posedge clock);
		reset_pin_n <= 1'b0;
		repeat (5) @(posedge clock);
		reset_pin_n <= 1'b1;
		#1;
		`CHK(restart, 1'b0)
		@(posedge clock);
		reset_pin_n <= 1'b0;
		repeat (8) @(posedge clock);
		#1;
		`CHK(restart, 1'b1)
		`CHK(restart_addr, 20'h00000)
		@(posedge clock);
		reset_pin_n <= 1'b1;
		$display("t_rst done");
	endtask

	// Main sequence
	initial begin
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		t_mem();
		t_io();
		t_win();
		t_hold();
		t_rst();
		results();
	end
endmodule
